/* File: design/parport_floppy_pin_mux.sv */
// floppy-over-parallel pin multiplexer with its axi4-lite register slave
`timescale 1ns/1ps
`include "parport_floppy_pin_mux_consts.svh"

module parport_floppy_pin_mux #(
  parameter int ADDR_W = 12
) (
  input wire logic core_clk,
  input wire logic rstn,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // floppy controller core side
  input wire parport_floppy_pin_mux_pkg::fdc_out_t fdc_core_out,
  input wire logic [1:0] fdc_drive_sel,
  output parport_floppy_pin_mux_pkg::fdc_in_t fdc_core_in,
  // native floppy pins
  output parport_floppy_pin_mux_pkg::fdc_out_t fdc_native_out,
  output parport_floppy_pin_mux_pkg::fdc_out_t fdc_native_oe_n,
  input wire parport_floppy_pin_mux_pkg::fdc_in_t fdc_native_in,
  // parallel connector pins
  input wire parport_floppy_pin_mux_pkg::pp_pins_t pp_pin_in,
  output parport_floppy_pin_mux_pkg::pp_pins_t pp_pin_out,
  output parport_floppy_pin_mux_pkg::pp_pins_t pp_pin_oe_n,
  // parallel port dma and interrupt
  input wire logic port_dma_acknowledge,
  input wire logic port_dma_req_core,
  output logic port_dma_ack_core,
  output logic port_dma_request,
  output logic port_dma_request_oe_n,
  output logic port_interrupt_out,
  output logic port_interrupt_out_oe_n
);
  import parport_floppy_pin_mux_pkg::*;

  // registers
  logic [7:0] data_q;
  logic [7:0] ctrl_q;
  logic [7:0] cfg_q;
  logic [7:0] mode_q;

  // synchronisers: first stage read only by the second
  pp_pins_t pp_meta_q;
  pp_pins_t pp_sync_q;
  fdc_in_t fdc_meta_q;
  fdc_in_t fdc_sync_q;
  logic dack_meta_q;
  logic dack_sync_q;

  // bus state
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] rd_byte;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;

  // mux state
  mux_mode_t mode;
  logic floppy_on;
  logic port_on;
  logic routed_sel;
  pp_pins_t pp_out_d;
  pp_pins_t pp_oe_n_d;
  fdc_in_t fdc_in_d;
  logic drq_d;
  logic drq_oe_n_d;
  logic irq_d;
  logic irq_oe_n_d;

  // two-flop synchronisers for everything arriving from pins
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pp_meta_q <= '1;
      pp_sync_q <= '1;
      fdc_meta_q <= '1;
      fdc_sync_q <= '1;
      dack_meta_q <= 1'b1;
      dack_sync_q <= 1'b1;
    end
    else
    begin
      pp_meta_q <= pp_pin_in;
      pp_sync_q <= pp_meta_q;
      fdc_meta_q <= fdc_native_in;
      fdc_sync_q <= fdc_meta_q;
      dack_meta_q <= port_dma_acknowledge;
      dack_sync_q <= dack_meta_q;
    end
  end

  // mode decode; hi bit wins so both set means two drives
  always_comb
  begin
    if (mode_q[`MODE_CTRL_HI])
      mode = FLOPPY_DUAL_DRIVE_MUX;
    else if (mode_q[`MODE_CTRL_LO])
      mode = FLOPPY_SINGLE_DRIVE_MUX;
    else
      mode = MUX_NORMAL;
  end

  // power bit only gates the parallel port, never the floppy path
  assign floppy_on = (mode != MUX_NORMAL);
  assign port_on = !floppy_on && cfg_q[`CFG_POWER];

  // is the drive currently selected by the controller the one on the connector
  always_comb
  begin
    unique case (mode)
      FLOPPY_SINGLE_DRIVE_MUX: routed_sel = fdc_drive_sel[1];
      FLOPPY_DUAL_DRIVE_MUX: routed_sel = |fdc_drive_sel;
      default: routed_sel = 1'b0;
    endcase
  end

  // connector pin drive; everything released by default
  always_comb
  begin
    pp_out_d = '0;
    pp_oe_n_d = '1;
    if (floppy_on)
    begin
      // control pins become floppy outputs
      pp_out_d.ack = fdc_core_out.drive_select_one;
      pp_out_d.busy = fdc_core_out.motor_on_one;
      pp_out_d.paper_end = fdc_core_out.write_data_out;
      pp_out_d.select = fdc_core_out.write_gate;
      pp_out_d.autofd = fdc_core_out.density_select;
      pp_out_d.error = fdc_core_out.head_select;
      pp_out_d.init = fdc_core_out.step_direction;
      pp_out_d.selin = fdc_core_out.step_pulse;
      pp_oe_n_d.ack = 1'b0;
      pp_oe_n_d.busy = 1'b0;
      pp_oe_n_d.paper_end = 1'b0;
      pp_oe_n_d.select = 1'b0;
      pp_oe_n_d.autofd = 1'b0;
      pp_oe_n_d.error = 1'b0;
      pp_oe_n_d.init = 1'b0;
      pp_oe_n_d.selin = 1'b0;
      // data 0-4 stay inputs, data 5 and 7 are left floating
      if (mode == FLOPPY_DUAL_DRIVE_MUX)
      begin
        pp_out_d.strobe = fdc_core_out.drive_select_zero;
        pp_out_d.data[6] = fdc_core_out.motor_on_zero;
        pp_oe_n_d.strobe = 1'b0;
        pp_oe_n_d.data[6] = 1'b0;
      end
    end
    else if (port_on)
    begin
      // plain port, data lines released while the ctrl dir bit is set; control pins are active-low except init
      pp_out_d.data = data_q;
      pp_oe_n_d.data = {8{ctrl_q[`CTRL_DIR]}};
      pp_out_d.strobe = !ctrl_q[`CTRL_STROBE];
      pp_out_d.autofd = !ctrl_q[`CTRL_AUTOFD];
      pp_out_d.init = ctrl_q[`CTRL_INIT];
      pp_out_d.selin = !ctrl_q[`CTRL_SELIN];
      pp_oe_n_d.strobe = 1'b0;
      pp_oe_n_d.autofd = 1'b0;
      pp_oe_n_d.init = 1'b0;
      pp_oe_n_d.selin = 1'b0;
    end
  end

  // status inputs to the floppy controller come from the routed source
  always_comb
  begin
    if (routed_sel)
    begin
      fdc_in_d.index_pulse_in = pp_sync_q.data[0];
      fdc_in_d.track_zero_in = pp_sync_q.data[1];
      fdc_in_d.write_protect_in = pp_sync_q.data[2];
      fdc_in_d.read_data_in = pp_sync_q.data[3];
      fdc_in_d.disk_change_in = pp_sync_q.data[4];
    end
    else
      fdc_in_d = fdc_sync_q;
  end

  // dma request and interrupt pins
  always_comb
  begin
    drq_d = 1'b0;
    drq_oe_n_d = 1'b1;
    irq_d = 1'b0;
    irq_oe_n_d = 1'b1;
    if (floppy_on)
    begin
      // low only with ecp and dma enabled, else released
      drq_oe_n_d = !(cfg_q[`CFG_ECP] && cfg_q[`CFG_DMA_EN]);
      irq_oe_n_d = !cfg_q[`CFG_INT_LOW];
    end
    else if (port_on)
    begin
      drq_d = port_dma_req_core && cfg_q[`CFG_DMA_EN];
      drq_oe_n_d = !cfg_q[`CFG_ECP];
      irq_d = ctrl_q[`CTRL_IRQ_EN] && !pp_sync_q.ack;
      irq_oe_n_d = 1'b0;
    end
  end

  // every output leaves from a flop, one cycle behind core-side causes and three behind the pins
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pp_pin_out <= '0;
      pp_pin_oe_n <= '1;
      fdc_native_out <= '1;
      fdc_native_oe_n <= '0;
      fdc_core_in <= '1;
      port_dma_ack_core <= 1'b1;
      port_dma_request <= 1'b0;
      port_dma_request_oe_n <= 1'b1;
      port_interrupt_out <= 1'b0;
      port_interrupt_out_oe_n <= 1'b1;
    end
    else
    begin
      pp_pin_out <= pp_out_d;
      pp_pin_oe_n <= pp_oe_n_d;
      fdc_native_out <= fdc_core_out;
      fdc_native_oe_n <= routed_sel ? '1 : '0;
      fdc_core_in <= fdc_in_d;
      // acknowledge pin ignored in floppy mode, core sees it idle; otherwise synchronised pin passes through
      port_dma_ack_core <= floppy_on ? 1'b1 : dack_sync_q;
      port_dma_request <= drq_d;
      port_dma_request_oe_n <= drq_oe_n_d;
      port_interrupt_out <= irq_d;
      port_interrupt_out_oe_n <= irq_oe_n_d;
    end
  end

  // address decode
  assign wr_idx = awaddr_q[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
  assign rd_idx = s_axi_araddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];

  function automatic logic idx_mapped(input logic [7:0] idx, input logic writable);
    logic hit;
    hit = (idx == `IDX_PORT_DATA) || (idx == `IDX_PORT_CTRL) || (idx == `IDX_MUX_CFG) ||
          (idx == `IDX_MODE_SEL);
    if (!writable)
      hit = hit || (idx == `IDX_PORT_STAT) || (idx == `IDX_MUX_STAT);
    return hit;
  endfunction

  assign wr_ok = (awaddr_q[ADDR_W-1:`ADDR_TOP_LSB] == '0) && idx_mapped(wr_idx, 1'b1);
  assign rd_ok = (s_axi_araddr[ADDR_W-1:`ADDR_TOP_LSB] == '0) && idx_mapped(rd_idx, 1'b0);
  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;

  // write channels: address and data taken in either order, one write at a time
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register storage; only the low byte lane carries data
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      data_q <= `RST_DATA;
      ctrl_q <= `RST_CTRL;
      cfg_q <= `RST_CFG;
      mode_q <= `RST_MODE;
    end
    else if (do_write && wr_ok && wstrb_q[0])
    begin
      unique case (wr_idx)
        `IDX_PORT_DATA: data_q <= wdata_q[7:0];
        `IDX_PORT_CTRL: ctrl_q <= wdata_q[7:0];
        `IDX_MUX_CFG: cfg_q <= wdata_q[7:0];
        `IDX_MODE_SEL: mode_q <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // read data selection
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      `IDX_PORT_DATA:
        rd_byte = (port_on && ctrl_q[`CTRL_DIR]) ? pp_sync_q.data : data_q;
      `IDX_PORT_CTRL:
        rd_byte = floppy_on ? `CTRL_CABLE_OFF : ctrl_q;
      `IDX_PORT_STAT:
        rd_byte = floppy_on ? `STAT_CABLE_OFF :
                  {!pp_sync_q.busy, pp_sync_q.ack, pp_sync_q.paper_end, pp_sync_q.select,
                   pp_sync_q.error, 3'b000};
      `IDX_MUX_CFG:
        rd_byte = cfg_q;
      `IDX_MUX_STAT:
        rd_byte = {3'b000, routed_sel, port_on, floppy_on, mode};
      `IDX_MODE_SEL:
        rd_byte = mode_q;
      default: rd_byte = 8'h00;
    endcase
  end

  // read channel answers one cycle after the address is taken
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? {24'h000000, rd_byte} : 32'h0000_0000;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

/* File: design/parport_floppy_pin_mux_consts.svh */
// register indices, field positions and fixed values of the floppy pin multiplexer
`ifndef PARPORT_FLOPPY_PIN_MUX_CONSTS_SVH
`define PARPORT_FLOPPY_PIN_MUX_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_PORT_DATA 8'h00
`define IDX_PORT_CTRL 8'h01
`define IDX_PORT_STAT 8'h02
`define IDX_MUX_CFG 8'h04
`define IDX_MUX_STAT 8'h05
`define IDX_MODE_SEL 8'hf1

// address layout
`define ADDR_IDX_LSB 2
`define ADDR_IDX_MSB 9
`define ADDR_TOP_LSB 10

// port control register fields
`define CTRL_STROBE 0
`define CTRL_AUTOFD 1
`define CTRL_INIT 2
`define CTRL_SELIN 3
`define CTRL_IRQ_EN 4
`define CTRL_DIR 5

// mux configuration register fields
`define CFG_POWER 0
`define CFG_ECP 1
`define CFG_DMA_EN 2
`define CFG_INT_LOW 3

// mode select register fields
`define MODE_CTRL_LO 0
`define MODE_CTRL_HI 1

// fixed read values while the floppy path owns the connector
`define CTRL_CABLE_OFF 8'h04
`define STAT_CABLE_OFF 8'h48

// reset values
`define RST_DATA 8'h00
`define RST_CTRL 8'h00
`define RST_CFG 8'h00
`define RST_MODE 8'h00

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: design/parport_floppy_pin_mux_pkg.sv */
// types shared by the floppy pin multiplexer
package parport_floppy_pin_mux_pkg;

  // connector pins at pin level
  typedef struct packed {
    logic [7:0] data;
    logic strobe;
    logic autofd;
    logic init;
    logic selin;
    logic ack;
    logic busy;
    logic paper_end;
    logic select;
    logic error;
  } pp_pins_t;

  // floppy controller outputs at pin level
  typedef struct packed {
    logic write_data_out;
    logic density_select;
    logic head_select;
    logic write_gate;
    logic step_direction;
    logic step_pulse;
    logic drive_select_zero;
    logic drive_select_one;
    logic motor_on_zero;
    logic motor_on_one;
  } fdc_out_t;

  // floppy drive status inputs at pin level
  typedef struct packed {
    logic index_pulse_in;
    logic track_zero_in;
    logic write_protect_in;
    logic read_data_in;
    logic disk_change_in;
  } fdc_in_t;

  typedef enum logic [1:0] {
    MUX_NORMAL = 2'b00,
    FLOPPY_SINGLE_DRIVE_MUX = 2'b01,
    FLOPPY_DUAL_DRIVE_MUX = 2'b10
  } mux_mode_t;

endpackage

/* File: verification/floppy_drive_model.sv */
// floppy drive on the far end of the parallel cable, with wire resolution
`timescale 1ns/1ps
module floppy_drive_model
  import parport_floppy_pin_mux_pkg::*;
(
  input wire logic core_clk,
  input wire parport_floppy_pin_mux_pkg::fdc_in_t drive_status,
  input wire parport_floppy_pin_mux_pkg::pp_pins_t pp_pin_out,
  input wire parport_floppy_pin_mux_pkg::pp_pins_t pp_pin_oe_n,
  output parport_floppy_pin_mux_pkg::pp_pins_t pp_pin_in
);
  logic tog_q = 1'b0;
  logic [16:0] far_lvl;

  // released lines with no drive output toggle, so a stale value never passes
  always_ff @(posedge core_clk)
    tog_q <= ~tog_q;

  // drive status sits on data 0 to 4, index on data 0
  assign far_lvl = {{3{tog_q}}, drive_status.disk_change_in, drive_status.read_data_in,
    drive_status.write_protect_in, drive_status.track_zero_in, drive_status.index_pulse_in,
    {9{tog_q}}};
  assign pp_pin_in = (pp_pin_out & ~pp_pin_oe_n) | (far_lvl & pp_pin_oe_n);
endmodule

/* File: verification/floppy_mux_props.sv */
// concurrent checks on the ports of the floppy pin multiplexer
`timescale 1ns/1ps
`include "parport_floppy_pin_mux_consts.svh"
module floppy_mux_props
  import parport_floppy_pin_mux_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire parport_floppy_pin_mux_pkg::fdc_out_t fdc_core_out,
  input wire logic [1:0] fdc_drive_sel,
  input wire parport_floppy_pin_mux_pkg::fdc_in_t fdc_core_in,
  input wire parport_floppy_pin_mux_pkg::fdc_out_t fdc_native_oe_n,
  input wire parport_floppy_pin_mux_pkg::fdc_out_t fdc_native_out,
  input wire parport_floppy_pin_mux_pkg::fdc_in_t fdc_native_in,
  input wire parport_floppy_pin_mux_pkg::pp_pins_t pp_pin_in,
  input wire parport_floppy_pin_mux_pkg::pp_pins_t pp_pin_out,
  input wire parport_floppy_pin_mux_pkg::pp_pins_t pp_pin_oe_n,
  input wire logic port_dma_ack_core,
  input wire logic port_dma_request,
  input wire logic port_dma_request_oe_n,
  input wire logic port_interrupt_out,
  input wire logic port_interrupt_out_oe_n
);
  logic [7:0] idx_q;
  logic [7:0] wd_q;
  logic wen_q;
  logic bv_q;
  logic [1:0] mode_q;
  logic [3:0] cfg_q;
  logic [5:0] st_p_q;
  logic [3:0] rt_q;
  logic routed;
  logic settled;
  logic floppy;
  logic [4:0] pins_rev;

  // shadow of mode and config; commits one edge late so checks never race a change
  always_ff @(posedge core_clk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      idx_q <= s_axi_awaddr[9:2];
    if (s_axi_wvalid && s_axi_wready)
      wd_q <= s_axi_wdata[7:0];
    if (s_axi_wvalid && s_axi_wready)
      wen_q <= s_axi_wstrb[0];
  end

  always_ff @(posedge core_clk)
    if (!rstn)
    begin
      bv_q <= 1'b0;
      mode_q <= 2'b00;
      cfg_q <= 4'h0;
    end
    else
    begin
      bv_q <= s_axi_bvalid;
      if (s_axi_bvalid && !bv_q && s_axi_bresp == `RESP_OKAY && wen_q && idx_q == `IDX_MODE_SEL)
        mode_q <= wd_q[1:0];
      if (s_axi_bvalid && !bv_q && s_axi_bresp == `RESP_OKAY && wen_q && idx_q == `IDX_MUX_CFG)
        cfg_q <= wd_q[3:0];
    end

  // history of settings and of routed-drive selection
  always_ff @(posedge core_clk)
    if (!rstn)
    begin
      st_p_q <= 6'h00;
      rt_q <= 4'h0;
    end
    else
    begin
      st_p_q <= {mode_q, cfg_q};
      rt_q <= {rt_q[2:0], routed};
    end

  // dual wins when both mode bits are set
  assign routed = mode_q[1] ? |fdc_drive_sel : mode_q[0] & fdc_drive_sel[1];
  assign settled = {mode_q, cfg_q} == st_p_q;
  assign floppy = |mode_q;
  assign pins_rev = {pp_pin_in.data[0], pp_pin_in.data[1], pp_pin_in.data[2],
    pp_pin_in.data[3], pp_pin_in.data[4]};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  chk_irq_quiet: assert property (floppy && settled |-> !port_interrupt_out
    && port_interrupt_out_oe_n == !cfg_q[`CFG_INT_LOW]) else $error("interrupt active");
  chk_drq_state: assert property (floppy && settled |->
    port_dma_request_oe_n == !(cfg_q[`CFG_ECP] && cfg_q[`CFG_DMA_EN])
    && (port_dma_request_oe_n || !port_dma_request)) else $error("dma request state wrong");
  chk_dack_idle: assert property (floppy && settled |-> port_dma_ack_core)
    else $error("dma acknowledge reached engine");
  // native copy lags the core by one flop; the edge out of reset is skipped
  chk_native_copy: assert property ($past(rstn) |->
    fdc_native_out == $past(fdc_core_out)) else $error("native pin copy wrong");
  // unrouted status comes from the native pins through the synchroniser
  chk_native_route: assert property (settled && rt_q == 4'h0 && $past(rstn, 3) |->
    fdc_core_in == $past(fdc_native_in, 3)) else $error("native status not routed");
  chk_native_hiz: assert property (settled |->
    fdc_native_oe_n == {10{$past(routed)}}) else $error("native pins enable wrong");
  chk_spare_free: assert property (floppy && settled |->
    pp_pin_oe_n.data[5] && pp_pin_oe_n.data[7]) else $error("spare data line driven");
  chk_ctrl_drive: assert property (floppy && settled |-> {pp_pin_oe_n.ack,
    pp_pin_oe_n.busy, pp_pin_oe_n.paper_end, pp_pin_oe_n.select, pp_pin_oe_n.autofd,
    pp_pin_oe_n.error, pp_pin_oe_n.init, pp_pin_oe_n.selin} == 8'h00)
    else $error("floppy output pin released");
  chk_ctrl_map: assert property (floppy && settled |-> {pp_pin_out.ack, pp_pin_out.busy,
    pp_pin_out.paper_end, pp_pin_out.select, pp_pin_out.autofd, pp_pin_out.error,
    pp_pin_out.init, pp_pin_out.selin} == $past({fdc_core_out.drive_select_one,
    fdc_core_out.motor_on_one, fdc_core_out.write_data_out, fdc_core_out.write_gate,
    fdc_core_out.density_select, fdc_core_out.head_select, fdc_core_out.step_direction,
    fdc_core_out.step_pulse})) else $error("floppy output mapping wrong");
  chk_drive0_dir: assert property (floppy && settled |->
    pp_pin_oe_n.strobe == !mode_q[1] && pp_pin_oe_n.data[6] == !mode_q[1]
    && (!mode_q[1] || pp_pin_out.strobe == $past(fdc_core_out.drive_select_zero)))
    else $error("drive zero pins wrong");
  chk_status_route: assert property (floppy && settled && rt_q == 4'hf |->
    fdc_core_in == $past(pins_rev, 3)) else $error("drive status not routed");
endmodule

/* File: verification/testbench.sv */
// self-checking bench for the floppy pin multiplexer
`timescale 1ns/1ps
`include "parport_floppy_pin_mux_consts.svh"
module testbench;
  import parport_floppy_pin_mux_pkg::*;
  localparam logic [11:0] A_DAT = `IDX_PORT_DATA * 4, A_CTL = `IDX_PORT_CTRL * 4;
  localparam logic [11:0] A_STA = `IDX_PORT_STAT * 4, A_CFG = `IDX_MUX_CFG * 4;
  localparam logic [11:0] A_MST = `IDX_MUX_STAT * 4, A_MOD = `IDX_MODE_SEL * 4;
  logic core_clk = 1'b0, rstn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, port_dma_ack_core, port_dma_request, port_dma_request_oe_n;
  logic port_interrupt_out, port_interrupt_out_oe_n;
  logic port_dma_acknowledge = 1, port_dma_req_core = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp, fdc_drive_sel = 2'b00;
  fdc_out_t fdc_core_out = '1, fdc_native_out, fdc_native_oe_n;
  fdc_in_t fdc_core_in, fdc_native_in = '1, drive_status = '1;
  pp_pins_t pp_pin_in, pp_pin_out, pp_pin_oe_n;
  logic [34:0] notes[$];
  logic [34:0] got, exp;
  logic [31:0] rng = 32'hb7e8;
  logic [7:0] cfg_tab[3] = '{8'h06, 8'h0b, 8'h0c};
  logic [7:0] dv;
  int mismatches = 0, samples_checked = 0, cycles = 0;

  parport_floppy_pin_mux u_dut (.*);
  floppy_drive_model u_drive (.*);

  initial
    forever #4 core_clk = ~core_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // random core and pin traffic every cycle, plus the hang limit
  always @(posedge core_clk)
  begin
    rng <= xs(rng);
    fdc_core_out <= rng[9:0];
    drive_status <= rng[14:10];
    fdc_native_in <= rng[19:15];
    port_dma_req_core <= rng[20];
    port_dma_acknowledge <= rng[21];
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    notes.push_back({1'b0, r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    fork
      begin
        do @(posedge core_clk); while (!s_axi_awready);
        s_axi_awvalid <= 0;
      end
      begin
        do @(posedge core_clk); while (!s_axi_wready);
        s_axi_wvalid <= 0;
      end
    join
    do @(posedge core_clk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    notes.push_back({1'b1, r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    @(posedge core_clk);
  endtask

  // answers are matched against the oldest note
  always @(posedge core_clk)
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
    begin
      got = s_axi_rvalid ? {1'b1, s_axi_rresp, s_axi_rdata} : {1'b0, s_axi_bresp, 32'h0};
      exp = notes.pop_front();
      samples_checked++;
      if (got !== exp)
      begin
        mismatches++;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
      end
    end

  initial
  begin
    repeat (20) @(posedge core_clk);
    rstn <= 1;
    @(posedge core_clk);
    rd(A_DAT, 0, `RESP_OKAY);
    rd(A_CFG, 0, `RESP_OKAY);
    rd(A_MOD, 0, `RESP_OKAY);
    rd(A_MST, 0, `RESP_OKAY);
    rd(12'h020, 0, `RESP_SLVERR);
    wr(A_STA, 8'h55, `RESP_SLVERR);
    wr(A_CFG, 8'h01, `RESP_OKAY);
    rd(A_MST, 32'h08, `RESP_OKAY);
    fdc_drive_sel <= 2'b10;
    for (int i = 0; i < 3; i++)
    begin
      dv = rng[7:0];
      wr(A_MOD, 8'(i + 1), `RESP_OKAY);
      wr(A_CFG, cfg_tab[i], `RESP_OKAY);
      wr(A_DAT, dv, `RESP_OKAY);
      wr(A_CTL, 8'h1f, `RESP_OKAY);
      rd(A_DAT, {24'h0, dv}, `RESP_OKAY);
      rd(A_CTL, `CTRL_CABLE_OFF, `RESP_OKAY);
      rd(A_STA, `STAT_CABLE_OFF, `RESP_OKAY);
      // drive 1 selected here: routed and floppy bits set, port bit clear
      rd(A_MST, {30'h5, (i == 0) ? 2'b01 : 2'b10}, `RESP_OKAY);
      for (int j = 0; j < 5; j++)
      begin
        fdc_drive_sel <= j[1:0] ^ 2'b10;
        repeat (30) @(posedge core_clk);
      end
    end
    wr(A_MOD, 8'h00, `RESP_OKAY);
    wr(A_CFG, 8'h01, `RESP_OKAY);
    rd(A_MST, 32'h08, `RESP_OKAY);
    wrap_up();
  end
endmodule

bind parport_floppy_pin_mux floppy_mux_props #(.ADDR_W(ADDR_W)) u_props (.*);
